// *** rtl/icrb_fifo.sv ***
// small request fifo in flip-flops
`timescale 1ns/10ps
module icrb_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  icrb_stream_if.snk in_s,
  icrb_stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  logic [W-1:0] mem_ff [DEPTH]; // storage, one word per entry
  logic [PW-1:0] wr_ptr_ff, nxt_wr_ptr; // next free entry
  logic [PW-1:0] rd_ptr_ff, nxt_rd_ptr; // oldest entry
  logic [CW-1:0] cnt_ff, nxt_cnt; // words held
  logic room_ff, nxt_room; // registered not-full, so ready comes straight from a flop
  logic push, pop;

  // handshakes on both sides
  always_comb begin
    push = in_s.valid & room_ff;
    pop = out_s.ready & (cnt_ff != '0);
    nxt_wr_ptr = push ? PW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
    nxt_rd_ptr = pop ? PW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
    nxt_cnt = CW'(cnt_ff + CW'(push) - CW'(pop));
    nxt_room = (nxt_cnt != CW'(DEPTH));
  end

  assign in_s.ready = room_ff;
  assign out_s.valid = (cnt_ff != '0);
  assign out_s.data = mem_ff[rd_ptr_ff];

  // pointer and level registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      room_ff <= 1'b1;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff <= nxt_cnt;
      room_ff <= nxt_room;
    end
  end

  // per-entry storage, written only on a push to that slot
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    logic [W-1:0] nxt_entry;
    always_comb begin
      nxt_entry = (push && wr_ptr_ff == PW'(g)) ? in_s.data : mem_ff[g];
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        mem_ff[g] <= '0;
      end else begin
        mem_ff[g] <= nxt_entry;
      end
    end
  end
endmodule : icrb_fifo

// *** rtl/icrb_map.svh ***
// constants of the configuration and readback bus master
`ifndef ICRB_MAP_SVH
`define ICRB_MAP_SVH
// target address width, wide enough to name a component in either channel
`define ICRB_ADDR_W 9
// configuration word width on the write side
`define ICRB_WDATA_W 12
// readback word width
`define ICRB_RDATA_W 12
// command code width and the codes this master acts on
`define ICRB_CODE_W 3
`define ICRB_CMD_SET_ADDR 3'h1
`define ICRB_CMD_BEGIN_READBACK 3'h3
// request word carried by the fifo: {is_data, code, word}
`define ICRB_REQ_W 16
`define ICRB_FIFO_DEPTH 4
// cycles a component may take to present a readback word
`define ICRB_RD_LATENCY 4
`define ICRB_TIMER_W 3
`endif

// *** rtl/icrb_master.sv ***
// configuration and readback bus master with request fifo
`timescale 1ns/10ps
`include "icrb_map.svh"

// Summary of operation
// - one-cycle write strobe per configuration word
// - write data valid only during strobe
// - address selects target, maybe two channels
// - begin-readback loads address, then read strobes
// - one-cycle read strobe per readback word
// - stop strobing once last word flagged
module icrb_master (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic i_req_is_data,
  input wire logic [`ICRB_CODE_W-1:0] i_req_code,
  input wire logic [`ICRB_WDATA_W-1:0] i_req_word,
  output logic o_req_ready,
  output logic [`ICRB_ADDR_W-1:0] o_target_select_bus,
  output logic o_write_strobe,
  output logic [`ICRB_WDATA_W-1:0] o_write_data_bus,
  output logic o_read_strobe,
  input wire logic [`ICRB_RDATA_W-1:0] i_read_data_bus,
  input wire logic i_last_word_flag,
  output logic o_rb_valid,
  output logic [`ICRB_RDATA_W-1:0] o_rb_word,
  output logic o_rb_last,
  input wire logic i_rb_ready,
  output logic o_busy
);

  // request path through the fifo
  icrb_stream_if #(.W(`ICRB_REQ_W)) req_in ();
  icrb_stream_if #(.W(`ICRB_REQ_W)) req_out ();

  // sequencing state
  icrb_pkg::icrb_state_t state_ff, nxt_state;

  // bus side registers
  logic [`ICRB_ADDR_W-1:0] addr_ff, nxt_addr; // selected target
  logic wr_stb_ff, nxt_wr_stb; // configuration write strobe
  logic [`ICRB_WDATA_W-1:0] wdata_ff, nxt_wdata; // write data, zero off strobe
  logic rd_stb_ff, nxt_rd_stb; // readback read strobe

  // readback hand-over registers
  logic rb_valid_ff, nxt_rb_valid; // captured word waiting for user
  logic [`ICRB_RDATA_W-1:0] rb_word_ff, nxt_rb_word; // captured word
  logic rb_last_ff, nxt_rb_last; // captured word closes the block
  logic busy_ff, nxt_busy; // readback sequence in progress

  // fifo head and control terms
  icrb_pkg::icrb_req_t head; // oldest queued request
  logic take; // head consumed this cycle
  logic timer_start; // read strobe just issued
  logic timer_expire; // latency window over, sample now

  // user request enters the fifo; ready is the fifo's registered not-full
  assign req_in.valid = i_req_valid;
  assign req_in.data = {i_req_is_data, i_req_code, i_req_word};
  assign o_req_ready = req_in.ready;

  // four-word queue keeps configuration words and commands in order,
  // so an address change never overtakes words meant for the old target
  icrb_fifo #(
    .W(`ICRB_REQ_W),
    .DEPTH(`ICRB_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .in_s(req_in),
    .out_s(req_out)
  );

  // latency timer for each readback word
  icrb_wait_timer u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(timer_start),
    // idle clears any leftover count, so no stale expiry meets a new strobe
    .i_abort(state_ff == icrb_pkg::ST_IDLE),
    .o_expire(timer_expire)
  );

  // head of queue decoded as a request
  assign head = icrb_pkg::icrb_req_t'(req_out.data);

  // the queue drains only while no readback runs; readback owns the bus
  assign req_out.ready = (state_ff == icrb_pkg::ST_IDLE);
  assign take = req_out.valid & req_out.ready;

  // the strobe cycle starts the latency window
  assign timer_start = rd_stb_ff;

  // next-state and bus value computation
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    // strobes fall back low unless re-raised below
    nxt_wr_stb = 1'b0;
    // data is cleared off the strobe cycle, nothing may rely on it
    nxt_wdata = '0;
    nxt_rb_valid = rb_valid_ff;
    nxt_rb_word = rb_word_ff;
    nxt_rb_last = rb_last_ff;
    unique case (state_ff)
      icrb_pkg::ST_IDLE: begin
        if (take) begin
          if (head.is_data) begin
            // one queued word gives exactly one strobe cycle
            nxt_wr_stb = 1'b1;
            nxt_wdata = head.word;
          end else if (head.code == `ICRB_CMD_SET_ADDR) begin
            // address may name one target or a pair across channels
            nxt_addr = head.word[`ICRB_ADDR_W-1:0];
          end else if (head.code == `ICRB_CMD_BEGIN_READBACK) begin
            // address first, strobes only from the cycle after next
            nxt_addr = head.word[`ICRB_ADDR_W-1:0];
            nxt_state = icrb_pkg::ST_RB_LOAD;
          end else begin
            // other command codes belong to other blocks, dropped here
            nxt_state = icrb_pkg::ST_IDLE;
          end
        end
      end
      icrb_pkg::ST_RB_LOAD: begin
        // address has stood one cycle, issue the first read strobe
        nxt_state = icrb_pkg::ST_RB_STROBE;
      end
      icrb_pkg::ST_RB_STROBE: begin
        // strobe is high in this cycle only
        nxt_state = icrb_pkg::ST_RB_WAIT;
      end
      icrb_pkg::ST_RB_WAIT: begin
        // the target's guaranteed latency is over: sample the bus
        if (timer_expire) begin
          nxt_rb_valid = 1'b1;
          nxt_rb_word = i_read_data_bus;
          nxt_rb_last = i_last_word_flag;
          nxt_state = icrb_pkg::ST_RB_HAND;
        end
      end
      icrb_pkg::ST_RB_HAND: begin
        // hold the word until the user takes it; a slow user stalls
        // the read strobes, which the target tolerates by holding data
        if (i_rb_ready) begin
          nxt_rb_valid = 1'b0;
          if (rb_last_ff) begin
            // last word seen: no further strobes
            nxt_state = icrb_pkg::ST_IDLE;
          end else begin
            nxt_state = icrb_pkg::ST_RB_STROBE;
          end
        end
      end
    endcase
    // strobe follows the strobe state one to one
    nxt_rd_stb = (nxt_state == icrb_pkg::ST_RB_STROBE);
    nxt_busy = (nxt_state != icrb_pkg::ST_IDLE);
  end

  // registers of the sequencer and the bus
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // reset abandons any readback and keeps both strobes low
      state_ff <= icrb_pkg::ST_IDLE;
      wr_stb_ff <= 1'b0;
      rd_stb_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
      rb_valid_ff <= 1'b0;
      rb_word_ff <= '0;
      rb_last_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wr_stb_ff <= nxt_wr_stb;
      rd_stb_ff <= nxt_rd_stb;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rb_valid_ff <= nxt_rb_valid;
      rb_word_ff <= nxt_rb_word;
      rb_last_ff <= nxt_rb_last;
      busy_ff <= nxt_busy;
    end
  end

  // outputs straight from the registers
  assign o_target_select_bus = addr_ff;
  assign o_write_strobe = wr_stb_ff;
  assign o_write_data_bus = wdata_ff;
  assign o_read_strobe = rd_stb_ff;
  assign o_rb_valid = rb_valid_ff;
  assign o_rb_word = rb_word_ff;
  assign o_rb_last = rb_last_ff;
  assign o_busy = busy_ff;

endmodule : icrb_master

// *** rtl/icrb_pkg.sv ***
// types of the configuration and readback bus master
`include "icrb_map.svh"
package icrb_pkg;
  // master sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RB_LOAD,
    ST_RB_STROBE,
    ST_RB_WAIT,
    ST_RB_HAND
  } icrb_state_t;
  // one queued request from the command side
  typedef struct packed {
    logic is_data;
    logic [`ICRB_CODE_W-1:0] code;
    logic [`ICRB_WDATA_W-1:0] word;
  } icrb_req_t;
endpackage : icrb_pkg

// *** rtl/icrb_stream_if.sv ***
// valid/ready stream between the master and its fifo
`timescale 1ns/10ps
interface icrb_stream_if #(parameter int W = 16);
  logic valid; // word offered
  logic ready; // word accepted when both high
  logic [W-1:0] data; // offered word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : icrb_stream_if

// *** rtl/icrb_wait_timer.sv ***
// down counter that marks the end of the readback latency
`timescale 1ns/10ps
`include "icrb_map.svh"
module icrb_wait_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_abort,
  output logic o_expire
);
  logic [`ICRB_TIMER_W-1:0] cnt_ff, nxt_cnt; // cycles left, 0 when idle

  // load on start, count down to zero
  always_comb begin
    if (i_abort) begin
      nxt_cnt = '0;
    end else if (i_start) begin
      nxt_cnt = `ICRB_TIMER_W'(`ICRB_RD_LATENCY);
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = '0;
    end
  end

  // expiry is the last counted cycle
  assign o_expire = (cnt_ff == `ICRB_TIMER_W'(1));

  // count register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : icrb_wait_timer

// *** tb/icrb_master_assertions.sv ***
// checker of the bus master port timing
`timescale 1ns/10ps
`include "icrb_map.svh"
module icrb_master_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [`ICRB_ADDR_W-1:0] o_target_select_bus,
  input wire logic o_write_strobe,
  input wire logic [`ICRB_WDATA_W-1:0] o_write_data_bus,
  input wire logic o_read_strobe,
  input wire logic [`ICRB_RDATA_W-1:0] i_read_data_bus,
  input wire logic i_last_word_flag,
  input wire logic o_rb_valid,
  input wire logic [`ICRB_RDATA_W-1:0] o_rb_word,
  input wire logic o_rb_last,
  input wire logic i_rb_ready,
  input wire logic o_busy
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // target latency window after a strobe
  sequence s_wait;
    (!o_read_strobe && !o_rb_valid) [*4];
  endsequence
  // user takes the captured word
  sequence s_take;
    o_rb_valid && i_rb_ready;
  endsequence
  wdata_idle_a: assert property (!o_write_strobe |-> o_write_data_bus == 12'h000)
    else $error("write data driven outside strobe");
  wr_quiet_a: assert property (o_busy |-> !o_write_strobe)
    else $error("write strobe during readback");
  rd_pulse_a: assert property (o_read_strobe |=> !o_read_strobe)
    else $error("read strobe longer than one cycle");
  rd_wait_a: assert property (o_read_strobe |=> s_wait ##1 o_rb_valid)
    else $error("readback word not captured after four cycles");
  rb_take_a: assert property ($rose(o_rb_valid) |-> o_rb_word == $past(i_read_data_bus)
    && o_rb_last == $past(i_last_word_flag)) else $error("captured word or flag wrong");
  rb_hold_a: assert property (o_rb_valid && !i_rb_ready |=> o_rb_valid && $stable(o_rb_word))
    else $error("captured word lost before taken");
  rb_next_a: assert property (s_take ##0 !o_rb_last |=> o_read_strobe && !o_rb_valid)
    else $error("no next strobe after word taken");
  rb_stop_a: assert property (s_take ##0 o_rb_last |=> !o_busy ##0 (!o_read_strobe) [*3])
    else $error("strobes go on after last word");
  addr_first_a: assert property (o_read_strobe |-> o_busy && $stable(o_target_select_bus))
    else $error("strobe without settled address");
  rst_quiet_a: assert property (disable iff (1'b0) !i_rst_n |-> !o_write_strobe
    && !o_read_strobe && !o_busy) else $error("strobes active in reset");
endmodule : icrb_master_chk
bind icrb_master icrb_master_chk u_icrb_master_chk (.i_clk, .i_rst_n, .o_target_select_bus,
  .o_write_strobe, .o_write_data_bus, .o_read_strobe, .i_read_data_bus, .i_last_word_flag,
  .o_rb_valid, .o_rb_word, .o_rb_last, .i_rb_ready, .o_busy);

// *** tb/icrb_target_model.sv ***
// behavioural configurable component on the far side of the bus
`timescale 1ns/10ps
`include "icrb_map.svh"
module icrb_target_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [`ICRB_ADDR_W-1:0] i_sel,
  input wire logic i_wr,
  input wire logic [`ICRB_WDATA_W-1:0] i_wdata,
  input wire logic i_rd,
  input wire logic [2:0] i_lat, // answer delay, 1 to 4 cycles
  input wire logic [3:0] i_nwords, // words in one block
  output logic [`ICRB_RDATA_W-1:0] o_rdata,
  output logic o_last
);
  logic [20:0] mem [8]; // captured {address, word}
  int wcnt; // words written since reset
  int rcnt; // position in the block
  int wait_n; // cycles until the word shows
  // answers slowly or promptly; lines churn until the word is ready
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wcnt <= 0;
      rcnt <= 0;
      wait_n <= 0;
      o_rdata <= 12'hA5A;
      o_last <= 1'b0;
    end else begin
      // keep the word now, the bus drops it next cycle
      if (i_wr) begin
        mem[wcnt[2:0]] <= {i_sel, i_wdata};
        wcnt <= wcnt + 1;
      end
      // the word shows in the i_lat-th cycle after the strobe cycle:
      // a prompt target answers on the strobe's own edge, a slow one
      // churns the lines until the word shows, which at i_lat 4 is the edge before the master samples
      if (i_rd && i_lat > 3'h1) begin
        wait_n <= int'(i_lat) - 1;
        o_rdata <= ~o_rdata;
        o_last <= ~o_last;
      end else if (!i_rd && wait_n > 1) begin
        wait_n <= wait_n - 1;
        o_rdata <= ~o_rdata;
        o_last <= ~o_last;
      end else if (i_rd || wait_n == 1) begin
        wait_n <= 0;
        o_rdata <= mem[rcnt[2:0]][11:0];
        o_last <= (rcnt == i_nwords - 1);
        rcnt <= (rcnt == i_nwords - 1) ? 0 : rcnt + 1;
      end
    end
  end
endmodule : icrb_target_model

// *** tb/test_internal_config_readback_bus.sv ***
// self-checking bench of the configuration and readback bus master
`timescale 1ns/10ps
`include "icrb_map.svh"
module test_internal_config_readback_bus;
  logic i_clk = 1'b0; // 200 MHz
  logic i_rst_n = 1'b1; // active low, pulled low at time zero for a real falling edge
  logic req_v = 1'b0, req_d = 1'b0, rb_rdy = 1'b0;
  logic [2:0] req_c = 3'h0, lat = 3'h1;
  logic [11:0] req_w = 12'h000;
  logic [3:0] nw = 4'h1;
  logic req_rdy, wr, rd, rb_v, rb_l, last, busy;
  logic [8:0] sel;
  logic [11:0] wdat, rdat, rb_w;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #2.5 i_clk = ~i_clk;
  icrb_master u_icrb_master (.i_clk, .i_rst_n, .i_req_valid(req_v), .i_req_is_data(req_d),
    .i_req_code(req_c), .i_req_word(req_w), .o_req_ready(req_rdy), .o_target_select_bus(sel),
    .o_write_strobe(wr), .o_write_data_bus(wdat), .o_read_strobe(rd), .i_read_data_bus(rdat),
    .i_last_word_flag(last), .o_rb_valid(rb_v), .o_rb_word(rb_w), .o_rb_last(rb_l),
    .i_rb_ready(rb_rdy), .o_busy(busy));
  icrb_target_model u_icrb_target_model (.i_clk, .i_rst_n, .i_sel(sel), .i_wr(wr),
    .i_wdata(wdat), .i_rd(rd), .i_lat(lat), .i_nwords(nw), .o_rdata(rdat), .o_last(last));
  task automatic cmp(input logic [20:0] got, input logic [20:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // offer a request, held until an edge sees ready
  task automatic push(input logic d, input logic [2:0] c, input logic [11:0] w);
    req_v <= 1'b1;
    req_d <= d;
    req_c <= c;
    req_w <= w;
    @(posedge i_clk iff req_rdy);
  endtask : push
  // take n words, stalling the user side first
  task automatic get_blk(input int n, input int stall);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk iff rb_v);
      repeat (stall) @(posedge i_clk);
      cmp({8'h00, rb_l, rb_w}, {8'h00, k == n - 1, u_icrb_target_model.mem[k][11:0]});
      rb_rdy <= 1'b1;
      @(posedge i_clk);
      rb_rdy <= 1'b0;
    end
    #1 cmp({20'h00000, busy}, 21'h000000);
    @(posedge i_clk);
  endtask : get_blk
  // one readback block from a given address
  task automatic t_rb(input logic [8:0] a, input int n, input logic [2:0] l, input int stall);
    lat <= l;
    nw <= n[3:0];
    push(1'b0, `ICRB_CMD_BEGIN_READBACK, {3'h0, a});
    req_v <= 1'b0;
    get_blk(n, stall);
    cmp({12'h000, sel}, {12'h000, a});
  endtask : t_rb
  // writes with a stray unknown code between them
  task automatic t_cfg;
    logic [11:0] ex [3] = '{12'hA01, 12'h5FE, 12'hFFF};
    push(1'b0, `ICRB_CMD_SET_ADDR, 12'h0A5);
    push(1'b1, 3'h0, ex[0]);
    push(1'b0, 3'h5, 12'h1FF);
    push(1'b1, 3'h0, ex[1]);
    push(1'b1, 3'h0, ex[2]);
    req_v <= 1'b0;
    repeat (20) @(posedge i_clk);
    cmp(21'(u_icrb_target_model.wcnt), 21'h000003);
    for (int i = 0; i < 3; i++)
      cmp(u_icrb_target_model.mem[i], {9'h0A5, ex[i]});
  endtask : t_cfg
  // a readback stalls the queue: fill until refused, drain in order
  task automatic t_fill;
    int base;
    base = u_icrb_target_model.wcnt;
    lat <= 3'h4;
    nw <= 4'h2;
    push(1'b0, `ICRB_CMD_BEGIN_READBACK, 12'h155);
    for (int i = 0; i < 4; i++)
      push(1'b1, 3'h0, 12'(12'h300 + i));
    req_v <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 cmp({20'h00000, req_rdy}, 21'h000000);
    cmp(21'(u_icrb_target_model.wcnt - base), 21'h000000);
    @(posedge i_clk);
    get_blk(2, 2);
    repeat (20) @(posedge i_clk);
    cmp(21'(u_icrb_target_model.wcnt - base), 21'h000004);
    cmp(u_icrb_target_model.mem[(base + 3) % 8], {9'h155, 12'h303});
  endtask : t_fill
  // reset in mid-block abandons the readback
  task automatic t_rst;
    lat <= 3'h2;
    nw <= 4'h3;
    push(1'b0, `ICRB_CMD_BEGIN_READBACK, 12'h0A5);
    req_v <= 1'b0;
    @(posedge i_clk iff rb_v);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 cmp({17'h00000, rd, wr, busy, rb_v}, 21'h000000);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
  endtask : t_rst
  initial begin
    // falling edge at time zero resets every flop before the first clock edge
    i_rst_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_cfg;
    t_rb(9'h0A5, 3, 3'h4, 3);
    t_rb(9'h1FF, 1, 3'h1, 0);
    t_fill;
    t_rst;
    t_rb(9'h002, 2, 3'h3, 0);
    close_out;
  end
  // watchdog far beyond the about 160 cycles the run needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      close_out;
    end
  end
endmodule : test_internal_config_readback_bus
